//--- rtl/nvm_cfg_defs.svh
// constants: register indices, field positions, reset values, memory bounds
//
// Overview of operation
// [R1] Low-voltage programming bit set: LV entry allowed, pin is reset, pin-enable bit ignored.
// [R2] Low-voltage programming bit clear: programming entry only by high voltage on pin.
// [R3] During a low-voltage session, a write clearing the low-voltage bit is refused.
// [R4] Bit 11 low write-protects storage area, only while storage area enabled.
// [R5] Bit 10 low write-protects data EEPROM, high leaves it writable.
// [R6] Bit 9 low write-protects configuration words, high leaves them writable.
// [R7] Bit 8 low write-protects boot block, only while boot block enabled.
// [R8] Bit 7 low write-protects application block, high leaves it writable.
// [R9] A cleared write-protect bit returns to unprotected only through bulk erase.
// [R10] Bit 4 low enables the storage flash area, high disables it.
// [R11] Bit 3 low enables the boot block partition, high disables it.
// [R12] Enabled boot block: size codes 111..011 give ends 01FF..1FFF; disabled ignores.
// [R13] Codes 010..000 give 3FFF, clamped to half of program memory.
// [R14] Size field changes only while boot block disabled; afterwards only bulk erase.
// [R15] Code-protect bit 1 low enables EEPROM read-out protection.
// [R16] Code-protect bit 0 low enables program flash read-out protection.
// [R17] Code protection acts at once; programmer should write it last.
// [R18] Enabled code protection is removed only through bulk erase.
// [R19] Part word: 12-bit part code in 11:0, bits 13 and 12 read one.
// [R20] Revision word: major 11:6, minor 5:0, bit 13 one, bit 12 zero.
// [R21] Write to protected location leaves memory unchanged and sets write-error flag.
// [R22] Enabled storage area is last 128 words and not executable.
// [R23] Decoded protection and partition are latched at reset and held.
`ifndef NVM_CFG_DEFS_SVH
`define NVM_CFG_DEFS_SVH

`define IDX_REVISION      16'h8005
`define IDX_PART          16'h8006
`define IDX_PROT          16'h800A
`define IDX_CODE_PROT     16'h800B
`define IDX_CTRL          16'h8010
`define IDX_STATUS        16'h8011
`define IDX_ACTIVE        16'h8012

`define BIT_LVP           13
`define BIT_SAF_WP        11
`define BIT_EEP_WP        10
`define BIT_CFG_WP        9
`define BIT_BOOT_WP       8
`define BIT_APP_WP        7
`define BIT_SAF_EN_N      4
`define BIT_BOOT_EN_N     3
`define BIT_CPD           1
`define BIT_CP            0

`define PROT_RESET        16'h2F9F
`define CODE_PROT_RESET   16'h0003
`define PROT_ONE_WAY_MASK 16'h0F98
`define CODE_PROT_MASK    16'h0003

`define BIT_CTRL_ERASE    0
`define BIT_CTRL_LVP_SESS 1
`define BIT_CTRL_RELATCH  2

`define PFM_LAST          15'h3FFF
`define PFM_HALF_LAST     15'h1FFF
`define SAF_FIRST         15'h3F80
`define CFG_BASE_HI       12'h800
`define EEP_BASE_HI       8'hF0

`endif

//--- rtl/nvm_cfg_pkg.sv
// types shared by the configuration decode block
package nvm_cfg_pkg;
	typedef enum logic [1:0] {
		ST_LOAD = 2'b01,
		ST_RUN  = 2'b10
	} state_type;

	typedef enum logic [2:0] {
		RG_APP  = 3'd0,
		RG_BOOT = 3'd1,
		RG_SAF  = 3'd2,
		RG_CFG  = 3'd3,
		RG_EEP  = 3'd4,
		RG_NONE = 3'd5
	} region_type;
endpackage : nvm_cfg_pkg

//--- rtl/cfg_decode_if.sv
// carrier between the register core and the partition decoder
`timescale 1ns/1ps
interface cfg_decode_if;
	logic [15:0] prot_word;
	logic [15:0] wr_addr;
	logic [14:0] fetch_addr;
	logic [14:0] boot_end;
	logic        boot_en;
	logic        saf_en;
	logic        wr_protected;
	logic        exec_denied;

	modport core (
		output prot_word,
		output wr_addr,
		output fetch_addr,
		input  boot_end,
		input  boot_en,
		input  saf_en,
		input  wr_protected,
		input  exec_denied
	);
	modport dec (
		input  prot_word,
		input  wr_addr,
		input  fetch_addr,
		output boot_end,
		output boot_en,
		output saf_en,
		output wr_protected,
		output exec_denied
	);
endinterface : cfg_decode_if

//--- rtl/partition_decode.sv
// partition map and write/execute protection decode of the latched word
`timescale 1ns/1ps
`include "nvm_cfg_defs.svh"
module partition_decode (
	cfg_decode_if.dec dif
);
	// shared by the write check and the fetch check
	function automatic nvm_cfg_pkg::region_type region_of(
		input logic [15:0] addr,
		input logic        boot_en,
		input logic        saf_en,
		input logic [14:0] boot_end
	);
		nvm_cfg_pkg::region_type r;
		r = nvm_cfg_pkg::RG_NONE;
		if (!addr[15]) begin
			if (boot_en && addr[14:0] <= boot_end)
				r = nvm_cfg_pkg::RG_BOOT;
			else if (saf_en && addr[14:0] >= `SAF_FIRST) // see [R22]
				r = nvm_cfg_pkg::RG_SAF;
			else
				r = nvm_cfg_pkg::RG_APP;
		end else if (addr[15:4] == `CFG_BASE_HI)
			r = nvm_cfg_pkg::RG_CFG;
		else if (addr[15:8] == `EEP_BASE_HI)
			r = nvm_cfg_pkg::RG_EEP;
		return r;
	endfunction : region_of

	wire [2:0]  size_code = dif.prot_word[2:0];
	wire [14:0] raw_end;
	wire [14:0] clamped_end;
	wire        wp_app  = ~dif.prot_word[`BIT_APP_WP];
	wire        wp_boot = ~dif.prot_word[`BIT_BOOT_WP];
	wire        wp_cfg  = ~dif.prot_word[`BIT_CFG_WP];
	wire        wp_eep  = ~dif.prot_word[`BIT_EEP_WP];
	wire        wp_saf  = ~dif.prot_word[`BIT_SAF_WP];
	nvm_cfg_pkg::region_type wr_region;
	nvm_cfg_pkg::region_type fetch_region;

	assign dif.boot_en = ~dif.prot_word[`BIT_BOOT_EN_N]; // see [R11]
	assign dif.saf_en  = ~dif.prot_word[`BIT_SAF_EN_N];  // see [R10]

	// see [R12] [R13]
	assign raw_end = (size_code == 3'b111) ? 15'h01FF :
	                 (size_code == 3'b110) ? 15'h03FF :
	                 (size_code == 3'b101) ? 15'h07FF :
	                 (size_code == 3'b100) ? 15'h0FFF :
	                 (size_code == 3'b011) ? 15'h1FFF : `PFM_LAST;
	// a boot block never passes half of program memory
	assign clamped_end = (raw_end > `PFM_HALF_LAST) ? `PFM_HALF_LAST : raw_end;
	assign dif.boot_end = dif.boot_en ? clamped_end : 15'h0000; // see [R12]

	assign wr_region = region_of(dif.wr_addr, dif.boot_en, dif.saf_en,
	                             clamped_end);
	assign fetch_region = region_of({1'b0, dif.fetch_addr}, dif.boot_en,
	                                dif.saf_en, clamped_end);

	// boot and storage regions only exist while enabled, so their
	// protect bits only matter then
	assign dif.wr_protected =
		(wr_region == nvm_cfg_pkg::RG_APP  && wp_app)  || // see [R8]
		(wr_region == nvm_cfg_pkg::RG_BOOT && wp_boot) || // see [R7]
		(wr_region == nvm_cfg_pkg::RG_SAF  && wp_saf)  || // see [R4]
		(wr_region == nvm_cfg_pkg::RG_CFG  && wp_cfg)  || // see [R6]
		(wr_region == nvm_cfg_pkg::RG_EEP  && wp_eep);    // see [R5]

	assign dif.exec_denied = (fetch_region == nvm_cfg_pkg::RG_SAF); // see [R22]
endmodule : partition_decode

//--- rtl/nvm_config_protection_decode.sv
// configuration word store, protection decode and AHB-Lite register slave
`timescale 1ns/1ps
`include "nvm_cfg_defs.svh"
module nvm_config_protection_decode #(
	parameter logic [11:0] PART_CODE      = 12'h5A5, // arbitrary value
	parameter logic [5:0]  MAJOR_REVISION = 6'h01,   // arbitrary value
	parameter logic [5:0]  MINOR_REVISION = 6'h02    // arbitrary value
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        reset_pin_enable,
	input  wire logic        hv_on_reset_pin,
	input  wire logic        lvp_entry_pin,
	input  wire logic        relatch_req,
	input  wire logic        nvm_wr_req,
	input  wire logic [15:0] nvm_wr_addr,
	input  wire logic [14:0] fetch_addr,
	output logic             low_voltage_prog_enable,
	output logic             reset_pin_function,
	output logic             prog_entry,
	output logic             nvm_wr_reject,
	output logic             write_error_flag,
	output logic             exec_denied,
	output logic             eeprom_read_protect,
	output logic             program_flash_read_protect,
	output logic [14:0]      boot_block_end,
	output logic             boot_block_enabled,
	output logic             storage_area_enabled
);
	cfg_decode_if dif ();

	partition_decode u_decode (
		.dif (dif.dec)
	);

	// stored words, latched copy and control state
	logic [15:0]            prot_reg;
	logic [15:0]            prot_next;
	logic [15:0]            cprot_reg;
	logic [15:0]            cprot_next;
	logic [15:0]            active_reg;
	logic                   lvp_sess_reg;
	logic                   werr_reg;
	logic                   werr_next;
	nvm_cfg_pkg::state_type state_reg;
	nvm_cfg_pkg::state_type state_next;

	// bus phase registers
	logic                   wr_pend_reg;
	logic [15:0]            wr_idx_reg;
	logic [31:0]            hrdata_reg;

	// pin synchronisers and registered decoder outputs
	logic [1:0]             hv_sync_reg;
	logic [1:0]             lvp_sync_reg;
	logic [14:0]            boot_end_reg;
	logic                   boot_en_reg;
	logic                   saf_en_reg;

	// ---------------- address decode ----------------
	wire        addr_phase = hsel && htrans[1] && hready;
	wire [15:0] ap_idx     = haddr[17:2];
	wire        ap_in_map  = (haddr[31:18] == 14'h0000);
	wire        ap_read    = addr_phase && !hwrite;
	wire        lvp_active = lvp_sess_reg || lvp_sync_reg[1];

	wire [31:0] rev_word  = {18'h00000, 2'b10, MAJOR_REVISION,
	                         MINOR_REVISION}; // see [R20]
	wire [31:0] part_word = {18'h00000, 2'b11, PART_CODE}; // see [R19]
	wire [31:0] ctrl_word = {30'h00000000, lvp_sess_reg, 1'b0};
	wire [31:0] stat_word = {24'h000000, 1'b0, saf_en_reg, boot_en_reg,
	                         lvp_active, prog_entry, exec_denied,
	                         nvm_wr_reject, werr_reg};

	// unmapped offsets read as zero with an OKAY response
	wire [31:0] rd_value =
		!ap_in_map                   ? 32'h00000000 :
		(ap_idx == `IDX_REVISION)    ? rev_word :
		(ap_idx == `IDX_PART)        ? part_word :
		(ap_idx == `IDX_PROT)        ? {16'h0000, prot_reg} :
		(ap_idx == `IDX_CODE_PROT)   ? {16'h0000, cprot_reg} :
		(ap_idx == `IDX_CTRL)        ? ctrl_word :
		(ap_idx == `IDX_STATUS)      ? stat_word :
		(ap_idx == `IDX_ACTIVE)      ? {16'h0000, active_reg} :
		                               32'h00000000;

	// ---------------- data phase write decode ----------------
	wire        wr_prot   = wr_pend_reg && (wr_idx_reg == `IDX_PROT);
	wire        wr_cprot  = wr_pend_reg && (wr_idx_reg == `IDX_CODE_PROT);
	wire        wr_ctrl   = wr_pend_reg && (wr_idx_reg == `IDX_CTRL);
	wire        wr_status = wr_pend_reg && (wr_idx_reg == `IDX_STATUS);
	wire [15:0] wdata     = hwdata[15:0];

	wire        bulk_erase  = wr_ctrl && hwdata[`BIT_CTRL_ERASE];
	wire        relatch_sw  = wr_ctrl && hwdata[`BIT_CTRL_RELATCH];
	// configuration protection follows the latched word
	wire        cfg_locked  = ~active_reg[`BIT_CFG_WP]; // see [R6]
	wire        lvp_drop    = lvp_active && prot_reg[`BIT_LVP] &&
	                          !wdata[`BIT_LVP];          // see [R3]
	wire        prot_refuse = wr_prot && (cfg_locked || lvp_drop);
	wire        cprot_refuse = wr_cprot && cfg_locked;
	wire        bus_refused = (prot_refuse || cprot_refuse) && !bulk_erase;
	wire        boot_was_off = prot_reg[`BIT_BOOT_EN_N];

	// protect and enable bits only move towards their active (low)
	// state; a write can never lift them, so software cannot undo a
	// protection without the erase path
	wire [15:0] prot_one_way = (prot_reg & wdata) & `PROT_ONE_WAY_MASK; // see [R9]
	wire [2:0]  size_keep    = boot_was_off ? wdata[2:0]
	                                        : prot_reg[2:0]; // see [R14]
	wire [15:0] prot_written = {2'b00, wdata[`BIT_LVP], 1'b0, 12'h000}
	                           | prot_one_way
	                           | {13'h0000, size_keep};

	// ---------------- next-state logic ----------------
	always_comb begin
		prot_next = prot_reg;
		if (bulk_erase)
			prot_next = `PROT_RESET; // see [R9] [R14]
		else if (wr_prot && !prot_refuse)
			prot_next = prot_written;
	end

	always_comb begin
		cprot_next = cprot_reg;
		if (bulk_erase)
			cprot_next = `CODE_PROT_RESET; // see [R18]
		else if (wr_cprot && !cprot_refuse)
			cprot_next = cprot_reg & wdata & `CODE_PROT_MASK; // see [R18]
	end

	// a new error in the clearing cycle wins over the clear
	always_comb begin
		werr_next = werr_reg;
		if (wr_status && hwdata[0])
			werr_next = 1'b0;
		if ((nvm_wr_req && nvm_wr_reject) || bus_refused)
			werr_next = 1'b1; // see [R21]
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			nvm_cfg_pkg::ST_LOAD: begin
				state_next = nvm_cfg_pkg::ST_RUN;
			end
			nvm_cfg_pkg::ST_RUN: begin
				if (relatch_req || relatch_sw)
					state_next = nvm_cfg_pkg::ST_LOAD;
			end
			default: begin
				state_next = nvm_cfg_pkg::ST_LOAD;
			end
		endcase
	end

	// ---------------- flip-flops ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prot_reg  <= `PROT_RESET;
			cprot_reg <= `CODE_PROT_RESET;
			werr_reg  <= 1'b0;
			state_reg <= nvm_cfg_pkg::ST_LOAD;
		end else begin
			prot_reg  <= prot_next;
			cprot_reg <= cprot_next;
			werr_reg  <= werr_next;
			state_reg <= state_next;
		end
	end

	// the partition is caught after each reset or relatch and then frozen, so a
	// protection change only reaches the write checker after a relatch, since reset also reloads the stored word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			active_reg <= `PROT_RESET;
		else if (state_reg == nvm_cfg_pkg::ST_LOAD)
			active_reg <= prot_reg; // see [R23]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_end_reg <= 15'h0000;
			boot_en_reg  <= 1'b0;
			saf_en_reg   <= 1'b0;
		end else begin
			boot_end_reg <= dif.boot_end;
			boot_en_reg  <= dif.boot_en;
			saf_en_reg   <= dif.saf_en;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			lvp_sess_reg <= 1'b0;
		else if (wr_ctrl)
			lvp_sess_reg <= hwdata[`BIT_CTRL_LVP_SESS];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hv_sync_reg  <= 2'b00;
			lvp_sync_reg <= 2'b00;
		end else begin
			hv_sync_reg  <= {hv_sync_reg[0], hv_on_reset_pin};
			lvp_sync_reg <= {lvp_sync_reg[0], lvp_entry_pin};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 16'h0000;
		end else if (hready) begin
			wr_pend_reg <= addr_phase && hwrite && ap_in_map;
			wr_idx_reg  <= ap_idx;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_reg <= 32'h00000000;
		else if (ap_read)
			hrdata_reg <= rd_value;
	end

	// ---------------- decoder hookup ----------------
	assign dif.prot_word  = active_reg; // see [R23]
	assign dif.wr_addr    = nvm_wr_addr;
	assign dif.fetch_addr = fetch_addr;

	// ---------------- outputs ----------------
	// zero wait state slave, every answer is OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	assign low_voltage_prog_enable = active_reg[`BIT_LVP]; // see [R1]
	// with low-voltage programming on, the pin stays a reset pin
	assign reset_pin_function = active_reg[`BIT_LVP] ||
	                            reset_pin_enable;       // see [R1]
	assign prog_entry = active_reg[`BIT_LVP] ? lvp_sync_reg[1]
	                                         : hv_sync_reg[1]; // see [R1] [R2]

	assign nvm_wr_reject    = nvm_wr_req && dif.wr_protected; // see [R21]
	assign write_error_flag = werr_reg;
	assign exec_denied      = dif.exec_denied; // see [R22]

	// read-out protection follows the stored word with no latching
	assign eeprom_read_protect =
		~cprot_reg[`BIT_CPD]; // see [R15] [R17]
	assign program_flash_read_protect =
		~cprot_reg[`BIT_CP];  // see [R16] [R17]

	assign boot_block_end       = boot_end_reg;
	assign boot_block_enabled   = boot_en_reg;
	assign storage_area_enabled = saf_en_reg;
endmodule : nvm_config_protection_decode

//--- testbench/nvm_cfg_properties.sv
// concurrent checks on the ports of the configuration decode block
`timescale 1ns/1ps
`include "nvm_cfg_defs.svh"
module nvm_cfg_properties (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        reset_pin_enable,
	input wire logic        hv_on_reset_pin,
	input wire logic        lvp_entry_pin,
	input wire logic        relatch_req,
	input wire logic        nvm_wr_req,
	input wire logic [14:0] fetch_addr,
	input wire logic        low_voltage_prog_enable,
	input wire logic        reset_pin_function,
	input wire logic        prog_entry,
	input wire logic        nvm_wr_reject,
	input wire logic        write_error_flag,
	input wire logic        exec_denied,
	input wire logic        eeprom_read_protect,
	input wire logic        program_flash_read_protect,
	input wire logic [14:0] boot_block_end,
	input wire logic        boot_block_enabled,
	input wire logic        storage_area_enabled
);
	logic ctrl_wr_q;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// only a control write (bulk erase) may lift read protection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_wr_q <= 1'b0;
		else
			ctrl_wr_q <= hsel && htrans[1] && hready && hwrite
				&& haddr == `IDX_CTRL * 4;
	end
	sequence quiet_relatch;
		!relatch_req [*3];
	endsequence
	sequence pins_steady;
		($stable(hv_on_reset_pin) && $stable(lvp_entry_pin)
			&& $stable(low_voltage_prog_enable)) [*5];
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or errored");
	a_lvp_pin_reset: assert property (
		low_voltage_prog_enable |-> reset_pin_function)
		else $error("pin lost reset role");
	a_pin_enable_used: assert property (
		!low_voltage_prog_enable |-> reset_pin_function == reset_pin_enable)
		else $error("pin role ignores enable bit");
	a_entry_path: assert property (
		pins_steady |-> prog_entry
			== (low_voltage_prog_enable ? lvp_entry_pin : hv_on_reset_pin))
		else $error("programming entry from wrong pin");
	a_reject_needs_req: assert property (!nvm_wr_req |-> !nvm_wr_reject)
		else $error("reject without request");
	a_reject_sets_err: assert property (
		nvm_wr_reject |=> write_error_flag)
		else $error("reject did not raise error flag");
	a_exec_window: assert property (
		quiet_relatch |-> exec_denied
			== (storage_area_enabled && fetch_addr >= `SAF_FIRST))
		else $error("execution denial outside storage area");
	a_boot_end_legal: assert property (
		boot_block_enabled ? boot_block_end inside {15'h01FF, 15'h03FF,
			15'h07FF, 15'h0FFF, 15'h1FFF} : boot_block_end == 15'h0000)
		else $error("boot block end not a legal value");
	a_decode_held: assert property (
		quiet_relatch |=> $stable(boot_block_end) && $stable(boot_block_enabled)
			&& $stable(storage_area_enabled)
			&& $stable(low_voltage_prog_enable))
		else $error("decode changed without reset");
	a_read_prot_kept: assert property (
		$fell(eeprom_read_protect) || $fell(program_flash_read_protect)
			|-> $past(ctrl_wr_q) || $past(ctrl_wr_q, 2))
		else $error("read protection lifted without erase");
endmodule : nvm_cfg_properties

bind nvm_config_protection_decode nvm_cfg_properties u_nvm_cfg_properties (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .reset_pin_enable, .hv_on_reset_pin, .lvp_entry_pin, .relatch_req,
	.nvm_wr_req, .fetch_addr, .low_voltage_prog_enable, .reset_pin_function,
	.prog_entry, .nvm_wr_reject, .write_error_flag, .exec_denied,
	.eeprom_read_protect, .program_flash_read_protect, .boot_block_end,
	.boot_block_enabled, .storage_area_enabled);

//--- testbench/programmer_model.sv
// programmer side: entry pins and write-controller requests
`timescale 1ns/1ps
module programmer_model (
	input  wire logic        hclk,
	input  wire logic        nvm_wr_reject,
	output logic             hv_on_reset_pin,
	output logic             lvp_entry_pin,
	output logic             nvm_wr_req,
	output logic [15:0]      nvm_wr_addr
);
	logic seen_reject;
	initial begin
		hv_on_reset_pin = 1'b0;
		lvp_entry_pin = 1'b0;
		nvm_wr_req = 1'b0;
		nvm_wr_addr = 16'h0000;
		seen_reject = 1'b0;
	end
	task automatic enter(input logic hv, lv);
		@(posedge hclk);
		hv_on_reset_pin <= hv;
		lvp_entry_pin <= lv;
		// two sync stages plus margin before anyone looks
		repeat (6) @(posedge hclk);
	endtask : enter
	task automatic probe(input logic [15:0] a);
		@(posedge hclk);
		nvm_wr_req <= 1'b1;
		nvm_wr_addr <= a;
		@(posedge hclk);
		seen_reject = nvm_wr_reject;
		nvm_wr_req <= 1'b0;
		// a released address carries junk, never the last target
		nvm_wr_addr <= ~a;
		@(posedge hclk);
	endtask : probe
endmodule : programmer_model

//--- testbench/nvm_config_protection_decode_tb.sv
// self-checking bench for the configuration protection decode block
`timescale 1ns/1ps
`include "nvm_cfg_defs.svh"
module nvm_config_protection_decode_tb;
	localparam logic [11:0] PART   = 12'hA5C; // arbitrary value
	localparam logic [5:0]  MAJ    = 6'h2A;   // arbitrary value
	localparam logic [5:0]  MIN    = 6'h15;   // arbitrary value
	localparam logic [31:0] A_PROT = `IDX_PROT * 4;
	localparam logic [31:0] A_CP   = `IDX_CODE_PROT * 4;
	localparam logic [31:0] A_CTRL = `IDX_CTRL * 4;
	localparam logic [31:0] A_STAT = `IDX_STATUS * 4;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, pm;
	logic        reset_pin_enable, hv_on_reset_pin, lvp_entry_pin;
	logic        relatch_req, nvm_wr_req, nvm_wr_reject, prog_entry;
	logic        low_voltage_prog_enable, reset_pin_function;
	logic        write_error_flag, exec_denied, eeprom_read_protect;
	logic        program_flash_read_protect, boot_block_enabled;
	logic        storage_area_enabled;
	logic [15:0] nvm_wr_addr;
	logic [14:0] fetch_addr, boot_block_end;
	int          errors, n_compared, cycles;
	logic [15:0] p_addr [5] = '{16'h3F80, 16'hF000, 16'h8000, 16'h0000,
		16'h3000};
	int          p_bit [5] = '{11, 10, 9, 8, 7};

	nvm_config_protection_decode #(.PART_CODE(PART), .MAJOR_REVISION(MAJ),
		.MINOR_REVISION(MIN)) u_nvm_config_protection_decode (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.reset_pin_enable, .hv_on_reset_pin, .lvp_entry_pin, .relatch_req,
		.nvm_wr_req, .nvm_wr_addr, .fetch_addr, .low_voltage_prog_enable,
		.reset_pin_function, .prog_entry, .nvm_wr_reject, .write_error_flag,
		.exec_denied, .eeprom_read_protect, .program_flash_read_protect,
		.boot_block_end, .boot_block_enabled, .storage_area_enabled);
	programmer_model u_programmer_model (.hclk, .nvm_wr_reject,
		.hv_on_reset_pin, .lvp_entry_pin, .nvm_wr_req, .nvm_wr_addr);

	task automatic chk_word(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word
	task automatic chk_bit(input string nm, input logic e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic step(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : step
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdc(input string nm, input logic [31:0] a, e);
		bus(1'b0, a, 32'h0);
		chk_word(nm, e, rd);
	endtask : rdc
	task automatic relatch();
		relatch_req <= 1'b1;
		@(posedge hclk);
		relatch_req <= 1'b0;
		step(4);
	endtask : relatch
	function automatic logic [31:0] bend(input int c);
		case (c)
			7: return 32'h01FF;
			6: return 32'h03FF;
			5: return 32'h07FF;
			4: return 32'h0FFF;
			default: return 32'h1FFF;
		endcase
	endfunction : bend
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// whole run needs a few hundred cycles
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, relatch_req, reset_pin_enable} = '0;
		htrans = 2'b00;
		{haddr, hwdata} = '0;
		fetch_addr = 15'h0000;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		step(3);
		rdc("revision", `IDX_REVISION * 4, {18'h0, 2'b10, MAJ, MIN});
		rdc("part", `IDX_PART * 4, {18'h0, 2'b11, PART});
		rdc("prot reset", A_PROT, 32'h2F9F);
		rdc("cp reset", A_CP, 32'h0003);
		rdc("unmapped", 32'h0002_0100, 32'h0);
		chk_bit("lvp on", 1'b1, low_voltage_prog_enable);
		chk_bit("pin reset", 1'b1, reset_pin_function);
		u_programmer_model.enter(1'b1, 1'b0);
		chk_bit("hv entry", 1'b0, prog_entry);
		u_programmer_model.enter(1'b0, 1'b1);
		chk_bit("lv entry", 1'b1, prog_entry);
		u_programmer_model.enter(1'b0, 1'b0);
		wr(A_CTRL, 32'h2);
		wr(A_PROT, 32'h0F9F);
		step(1);
		chk_bit("lvp clear err", 1'b1, write_error_flag);
		rdc("lvp kept", A_PROT, 32'h2F9F);
		wr(A_STAT, 32'h1);
		wr(A_CTRL, 32'h0);
		for (int c = 0; c < 8; c++) begin
			wr(A_CTRL, 32'h1);
			wr(A_PROT, 32'h2F90 | c);
			relatch();
			chk_bit("boot on", 1'b1, boot_block_enabled);
			chk_word("boot end", bend(c), 32'(boot_block_end));
		end
		wr(A_PROT, 32'h2F91);
		rdc("size locked", A_PROT, 32'h2F97);
		wr(A_CTRL, 32'h1);
		wr(A_PROT, 32'h2F9C);
		relatch();
		chk_bit("boot off", 1'b0, boot_block_enabled);
		for (int i = 0; i < 5; i++) begin
			pm = 32'h2F80 & ~(32'h1 << p_bit[i]);
			wr(A_CTRL, 32'h1);
			wr(A_PROT, 32'h2F80);
			relatch();
			if (i == 0) begin
				chk_bit("saf on", 1'b1, storage_area_enabled);
				fetch_addr <= 15'h3F80;
				step(1);
				chk_bit("exec saf", 1'b1, exec_denied);
				fetch_addr <= 15'h3F7F;
				step(1);
				chk_bit("exec app", 1'b0, exec_denied);
			end
			u_programmer_model.probe(p_addr[i]);
			chk_bit("open", 1'b0, u_programmer_model.seen_reject);
			wr(A_PROT, pm);
			relatch();
			u_programmer_model.probe(p_addr[i]);
			chk_bit("locked", 1'b1, u_programmer_model.seen_reject);
			chk_bit("wr error", 1'b1, write_error_flag);
			wr(A_PROT, 32'h2F80);
			rdc("one way", A_PROT, pm);
			wr(A_STAT, 32'h1);
			step(1);
			chk_bit("err clear", 1'b0, write_error_flag);
		end
		wr(A_CTRL, 32'h1);
		wr(A_CP, 32'h2);
		step(1);
		chk_bit("pf prot", 1'b1, program_flash_read_protect);
		chk_bit("ee open", 1'b0, eeprom_read_protect);
		wr(A_CP, 32'h1);
		step(1);
		chk_bit("ee prot", 1'b1, eeprom_read_protect);
		wr(A_CP, 32'h3);
		rdc("cp kept", A_CP, 32'h0);
		wr(A_CTRL, 32'h1);
		rdc("cp erased", A_CP, 32'h3);
		step(1);
		chk_bit("pf open", 1'b0, program_flash_read_protect);
		wr(A_PROT, 32'h0F9F);
		relatch();
		chk_bit("lvp off", 1'b0, low_voltage_prog_enable);
		chk_bit("pin gpio", 1'b0, reset_pin_function);
		reset_pin_enable <= 1'b1;
		step(1);
		chk_bit("pin enable", 1'b1, reset_pin_function);
		u_programmer_model.enter(1'b0, 1'b1);
		chk_bit("lv refused", 1'b0, prog_entry);
		u_programmer_model.enter(1'b1, 1'b0);
		chk_bit("hv entry", 1'b1, prog_entry);
		finish_test();
	end
endmodule : nvm_config_protection_decode_tb
